/* common/adc_pkg.sv */
package adc_pkg;

  localparam int ADC_CLK_HZ = 25_000_000;
  localparam int ADC_CNT_W = 30;

  // Millisecond times round down to whole cycles
  localparam int ADC_CALL_WIN_S = 4;
  localparam logic [ADC_CNT_W-1:0] ADC_CALL_WIN_CYC = ADC_CNT_W'(ADC_CALL_WIN_S * ADC_CLK_HZ);
  localparam int ADC_CC_SETTLE_MS = 100;
  localparam logic [ADC_CNT_W-1:0] ADC_CC_SETTLE_CYC = ADC_CNT_W'((ADC_CLK_HZ / 1000) * ADC_CC_SETTLE_MS);
  localparam int ADC_RDL_DELAY_MS = 10;
  localparam logic [ADC_CNT_W-1:0] ADC_RDL_DELAY_CYC = ADC_CNT_W'((ADC_CLK_HZ / 1000) * ADC_RDL_DELAY_MS);
  localparam int ADC_FAR_TO_S = 40;
  localparam logic [ADC_CNT_W-1:0] ADC_FAR_TO_CYC = ADC_CNT_W'(ADC_FAR_TO_S * ADC_CLK_HZ);

  localparam int ADC_DIGIT_W = 4;
  localparam int ADC_DEPTH_LOG2 = 4;

  // Status byte bit positions, zero based
  localparam int ADC_SB_ACR = 2;
  localparam int ADC_SB_CC = 3;
  localparam int ADC_SB_RQS = 6;
  localparam int ADC_SB_NOTE = 7;
  // Talk byte 4 active flag position (DI07)
  localparam int ADC_TB4_ACTIVE = 6;

  localparam logic ADC_ACTIVE_RST = 1'b1;
  localparam logic ADC_RDL_RST = 1'b1;

  localparam int ADC_NPIN = 10;

  typedef enum logic [4:0] {
    ADC_IDLE = 5'b00001,
    ADC_LOAD = 5'b00010,
    ADC_SEND = 5'b00100,
    ADC_WAIT = 5'b01000,
    ADC_CONN = 5'b10000
  } adc_state_e;

endpackage

/* logic/adc_call_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_call_ctrl
  import adc_pkg::*;
#(
  parameter logic [ADC_CNT_W-1:0] CC_SETTLE_CYC = ADC_CC_SETTLE_CYC,
  parameter logic [ADC_CNT_W-1:0] CALL_WIN_CYC = ADC_CALL_WIN_CYC,
  parameter logic [ADC_CNT_W-1:0] RDL_DELAY_CYC = ADC_RDL_DELAY_CYC,
  parameter logic [ADC_CNT_W-1:0] FAR_TO_CYC = ADC_FAR_TO_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_dial_start,
  input wire logic cmd_digit_valid,
  input wire logic [ADC_DIGIT_W-1:0] cmd_digit,
  input wire logic cmd_dial_end,
  input wire logic cmd_disconnect,
  input wire logic cmd_notify,
  input wire logic serial_poll,
  input wire logic notify_delivered,
  input wire logic link_up,
  input wire logic ifc_pin,
  input wire logic srq_enable_pin,
  input wire logic dtr_off_button_pin,
  input wire logic pnd_pin,
  input wire logic acr_pin,
  input wire logic dsr_pin,
  input wire logic cts_pin,
  input wire logic cos_pin,
  input wire logic dlo_pin,
  input wire logic pwi_pin,
  output logic crq,
  output logic dpr,
  output logic [ADC_DIGIT_W-1:0] digit_out,
  output logic dtr,
  output logic led_addressed,
  output logic led_dialling,
  output logic busy,
  output logic active_mode,
  output logic call_complete,
  output logic remote_data_lost,
  output logic srq,
  output logic [7:0] status_byte,
  output logic [7:0] talk_byte1,
  output logic [7:0] talk_byte2,
  output logic [7:0] talk_byte4
);
  localparam int AW = ADC_DEPTH_LOG2;

  // Every pin goes through two flops before use
  logic [ADC_NPIN-1:0] pin_raw, pin_m_q, pin_s_q;
  assign pin_raw = {pwi_pin, dlo_pin, cos_pin, cts_pin, dsr_pin, acr_pin, pnd_pin,
                    dtr_off_button_pin, srq_enable_pin, ifc_pin};
  genvar gi;
  generate
    for (gi = 0; gi < ADC_NPIN; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pin_m_q[gi] <= 1'b0;
          pin_s_q[gi] <= 1'b0;
        end else begin
          pin_m_q[gi] <= pin_raw[gi];
          pin_s_q[gi] <= pin_m_q[gi];
        end
      end
    end
  endgenerate
  wire ifc_s = pin_s_q[0];
  wire srq_en_s = pin_s_q[1];
  wire dtr_btn_s = pin_s_q[2];
  wire pnd_s = pin_s_q[3];
  wire acr_s = pin_s_q[4];
  wire dsr_s = pin_s_q[5];
  wire cts_s = pin_s_q[6];
  wire cos_s = pin_s_q[7];
  wire dlo_s = pin_s_q[8];
  wire pwi_s = pin_s_q[9];

  adc_state_e state_q, state_d;
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [ADC_DIGIT_W-1:0] mem_rdata;
  logic [ADC_CNT_W-1:0] cc_cnt_q, rdl_cnt_q, far_cnt_q;
  logic acr_f_q, cc_f_q, note_f_q, rqs_q, note_pend_q, intent_q;

  // Instructions are refused while the call is being placed
  wire cmd_ok = ~busy;
  wire in_call = (state_q == ADC_SEND) || (state_q == ADC_WAIT);
  wire dial_go = cmd_ok & cmd_dial_start;
  wire disc_go = cmd_ok & cmd_disconnect;
  wire end_go = cmd_ok & cmd_dial_end & (state_q == ADC_LOAD);
  wire dig_wr = cmd_ok & cmd_digit_valid & (state_q == ADC_LOAD) & ((wr_ptr_q + 1'b1) != rd_ptr_q);
  wire digits_left = wr_ptr_q != rd_ptr_q;
  wire dsr_cts = dsr_s & cts_s;
  // A digit is offered only while the unit is not asking for the next one
  wire present = (state_q == ADC_SEND) & ~pnd_s & ~dpr & digits_left;
  wire taken = dpr & pnd_s;
  wire abort = in_call & (ifc_s | acr_s);
  // A call torn down in the same cycle must not also report completion
  wire cc_set = (state_q == ADC_WAIT) & dsr_cts & (cc_cnt_q == CC_SETTLE_CYC - 1'b1) & ~abort;
  wire rdl_target = ~(call_complete & link_up);
  wire rdl_flip = (remote_data_lost != rdl_target) & (rdl_cnt_q == RDL_DELAY_CYC - 1'b1);
  wire far_run = dtr & call_complete & remote_data_lost;
  wire far_fire = far_run & (far_cnt_q == FAR_TO_CYC - 1'b1);
  wire ev_acr = in_call & acr_s;
  wire ev_note = note_pend_q & notify_delivered;
  wire ev_rdl = rdl_flip & ~remote_data_lost & ~intent_q;
  wire any_ev = ev_acr | cc_set | ev_note | ev_rdl;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ADC_IDLE: if (dial_go) state_d = ADC_LOAD;
      ADC_LOAD: begin
        if (disc_go) state_d = ADC_IDLE;
        else if (end_go) state_d = ADC_SEND;
      end
      ADC_SEND: begin
        if (abort) state_d = ADC_IDLE;
        else if (!digits_left && !dpr && !pnd_s) state_d = ADC_WAIT;
      end
      ADC_WAIT: begin
        if (abort) state_d = ADC_IDLE;
        else if (cc_set) state_d = ADC_CONN;
      end
      ADC_CONN: begin
        if (disc_go) state_d = ADC_IDLE;
        else if (dial_go) state_d = ADC_LOAD;
      end
      default: state_d = ADC_IDLE;
    endcase
  end

  adc_digit_mem #(.W(ADC_DIGIT_W), .AW(AW)) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(dig_wr),
    .waddr(wr_ptr_q),
    .wdata(cmd_digit),
    .raddr(rd_ptr_q),
    .rdata(mem_rdata)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ADC_IDLE;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      dpr <= 1'b0;
      digit_out <= '0;
    end else begin
      state_q <= state_d;
      if (dial_go) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
      end else begin
        if (dig_wr) wr_ptr_q <= wr_ptr_q + 1'b1;
        if (taken) rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      dpr <= (present | dpr) & ~taken & ~abort;
      if (present) digit_out <= mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crq <= 1'b0;
      dtr <= 1'b0;
      active_mode <= ADC_ACTIVE_RST;
      intent_q <= 1'b0;
      busy <= 1'b0;
      led_addressed <= 1'b0;
      led_dialling <= 1'b0;
    end else begin
      busy <= (state_d == ADC_SEND) || (state_d == ADC_WAIT);
      led_addressed <= (state_d != ADC_IDLE) && (state_d != ADC_CONN);
      led_dialling <= (state_d != ADC_IDLE) && (state_d != ADC_CONN);
      // Front-panel button drops DTR only; call request and mode stay put
      crq <= (crq | dial_go) & ~disc_go;
      dtr <= (dtr | dial_go) & ~disc_go & ~dtr_btn_s & ~far_fire;
      if (dial_go || disc_go) active_mode <= 1'b0;
      else if (end_go || cc_set) active_mode <= 1'b1;
      if (dial_go) intent_q <= 1'b0;
      else if (disc_go) intent_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cc_cnt_q <= '0;
      rdl_cnt_q <= '0;
      far_cnt_q <= '0;
      call_complete <= 1'b0;
      remote_data_lost <= ADC_RDL_RST;
    end else begin
      cc_cnt_q <= ((state_q == ADC_WAIT) && dsr_cts && !cc_set) ? cc_cnt_q + 1'b1 : '0;
      rdl_cnt_q <= ((remote_data_lost != rdl_target) && !rdl_flip) ? rdl_cnt_q + 1'b1 : '0;
      far_cnt_q <= (far_run && !far_fire) ? far_cnt_q + 1'b1 : '0;
      // Complete falls with DSR/CTS or when the call is torn down
      call_complete <= (call_complete | cc_set) & dsr_cts & (state_d == ADC_CONN);
      if (rdl_flip) remote_data_lost <= rdl_target;
    end
  end

  // Hardware sets win over a poll clearing in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acr_f_q <= 1'b0;
      cc_f_q <= 1'b0;
      note_f_q <= 1'b0;
      rqs_q <= 1'b0;
      note_pend_q <= 1'b0;
      srq <= 1'b0;
    end else begin
      acr_f_q <= ev_acr | (acr_f_q & ~serial_poll);
      cc_f_q <= cc_set | (cc_f_q & ~serial_poll);
      note_f_q <= ev_note | (note_f_q & ~serial_poll);
      rqs_q <= (srq_en_s & any_ev) | (rqs_q & ~serial_poll);
      srq <= (srq_en_s & any_ev) | (rqs_q & ~serial_poll);
      note_pend_q <= (note_pend_q | (cmd_ok & cmd_notify)) & ~notify_delivered;
    end
  end

  assign status_byte = {note_f_q, rqs_q, 2'b00, cc_f_q, acr_f_q, 2'b00};
  assign talk_byte1 = {3'b000, remote_data_lost, call_complete, acr_s, dsr_s, cts_s};
  assign talk_byte2 = {5'b00000, dlo_s, pwi_s, cos_s};
  assign talk_byte4 = {1'b0, active_mode, 6'b00_0000};

  a_dial_leds: assert property (@(posedge clk) disable iff (!rst_n)
    dial_go |=> led_addressed && led_dialling && crq) else $error("dial start did not light indicators");
  a_digit_pnd: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dpr) |-> !$past(pnd_s)) else $error("digit presented while next-digit line high");
  a_busy_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    busy && cmd_disconnect && !ifc_s && !acr_s |=> crq) else $error("instruction taken while busy");
  a_ifc_release: assert property (@(posedge clk) disable iff (!rst_n)
    in_call && ifc_s |=> ##1 !busy) else $error("interface clear did not release call");
  a_cc_window: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ADC_WAIT) && dsr_cts |-> cc_cnt_q < CALL_WIN_CYC) else $error("complete outside window");
  a_cc_active: assert property (@(posedge clk) disable iff (!rst_n)
    cc_set |=> active_mode && call_complete && status_byte[3]) else $error("completion did not set active");
  a_cc_rqs: assert property (@(posedge clk) disable iff (!rst_n)
    cc_set && srq_en_s |=> rqs_q && srq && status_byte[6]) else $error("no service request on completion");
  a_far_drop: assert property (@(posedge clk) disable iff (!rst_n)
    far_fire |=> !dtr) else $error("DTR not dropped after data-lost timeout");
  a_disc_idle: assert property (@(posedge clk) disable iff (!rst_n)
    disc_go |=> !crq && !active_mode && !dtr) else $error("disconnect did not idle");
  a_btn_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    dtr_btn_s && crq && !cmd_disconnect |=> crq && !dtr) else $error("button touched call request");
  a_intent_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    rdl_flip && intent_q && !rqs_q && !(ev_acr | cc_set | ev_note) |=> !rqs_q) else $error("request on intentional drop");
  a_note_bit: assert property (@(posedge clk) disable iff (!rst_n)
    ev_note |=> status_byte[7]) else $error("notify bit not set");

  c_call_done: cover property (@(posedge clk) disable iff (!rst_n) cc_set);
  c_abandon: cover property (@(posedge clk) disable iff (!rst_n) ev_acr);
  c_notify: cover property (@(posedge clk) disable iff (!rst_n) ev_note);
  c_ifc_abort: cover property (@(posedge clk) disable iff (!rst_n) in_call && ifc_s);
endmodule // adc_call_ctrl
`default_nettype wire

/* logic/adc_digit_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_digit_mem #(
  parameter int W = 4,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // adc_digit_mem
`default_nettype wire

/* verification/adc_acu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_acu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic crq,
  input wire logic dpr,
  input wire logic dtr,
  input wire logic abandon,
  input wire logic slow,
  input wire logic [3:0] ndig,
  output logic pnd_pin,
  output logic acr_pin,
  output logic dsr_pin,
  output logic cts_pin,
  output logic cos_pin,
  output wire logic dlo_pin,
  output wire logic pwi_pin
);
  logic [3:0] cnt_q;
  logic [1:0] dly_q;
  assign pwi_pin = 1'b1;
  assign dlo_pin = crq;
  always_ff @(posedge clk) begin
    if (!rst_n || !crq) begin
      pnd_pin <= 1'b0;
      acr_pin <= 1'b0;
      dsr_pin <= 1'b0;
      cts_pin <= 1'b0;
      cos_pin <= 1'b0;
      cnt_q <= 4'h0;
      dly_q <= 2'h0;
    end else begin
      // Slow mode takes a digit only after some idle cycles
      if (dpr && !pnd_pin) begin
        if (dly_q == (slow ? 2'h3 : 2'h0)) begin
          pnd_pin <= 1'b1;
          cnt_q <= cnt_q + 4'h1;
          dly_q <= 2'h0;
        end else begin
          dly_q <= dly_q + 2'h1;
        end
      end else if (!dpr && pnd_pin) begin
        pnd_pin <= 1'b0;
      end
      if (cnt_q == ndig && ndig != 4'h0 && !pnd_pin) begin
        if (abandon) begin
          acr_pin <= 1'b1;
        end else begin
          cos_pin <= 1'b1;
          dsr_pin <= dtr;
          cts_pin <= dtr;
        end
      end
    end
  end
endmodule // adc_acu_model
`default_nettype wire

/* verification/auto_dial_call_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module auto_dial_call_control_tb;
  logic clk = 0, rst_n = 0, dial_go = 0, dig_v = 0, dial_end = 0, disc = 0, note = 0, poll = 0, dlv = 0;
  logic link = 0, ifc = 0, sw7 = 0, ab = 0, slow = 0, btn = 0, pnd_q = 0;
  logic [3:0] dig_n = 4'h0;
  logic [3:0] dig = 4'h0, ndig = 4'h0;
  logic crq, dpr, dtr, led_a, led_d, busy, act, cc, rdl, srq, pnd, acr, dsr, cts, cos, dlo, pwi;
  logic [3:0] dig_o;
  logic [7:0] sb, t1, t2, t4;
  int mismatches = 0, check_count = 0, cyc = 0, win;
  // Rows: digits, {-, abandon, switch 7, slow}, expected status byte
  logic [15:0] rows [5] = '{16'h3248, 16'h1504, 16'hF108, 16'h2404, 16'h5348};
  always #20 clk = ~clk;
  adc_call_ctrl #(.CC_SETTLE_CYC(30'h0000_0004), .CALL_WIN_CYC(30'h0000_0014), .RDL_DELAY_CYC(30'h0000_0003),
    .FAR_TO_CYC(30'h0000_0032)) adc_call_ctrl_inst (.clk(clk), .rst_n(rst_n), .cmd_dial_start(dial_go),
    .cmd_digit_valid(dig_v), .cmd_digit(dig), .cmd_dial_end(dial_end), .cmd_disconnect(disc), .cmd_notify(note),
    .serial_poll(poll), .notify_delivered(dlv), .link_up(link), .ifc_pin(ifc), .srq_enable_pin(sw7),
    .dtr_off_button_pin(btn), .pnd_pin(pnd), .acr_pin(acr), .dsr_pin(dsr), .cts_pin(cts), .cos_pin(cos),
    .dlo_pin(dlo), .pwi_pin(pwi), .crq(crq), .dpr(dpr), .digit_out(dig_o), .dtr(dtr), .led_addressed(led_a),
    .led_dialling(led_d), .busy(busy), .active_mode(act), .call_complete(cc), .remote_data_lost(rdl), .srq(srq),
    .status_byte(sb), .talk_byte1(t1), .talk_byte2(t2), .talk_byte4(t4));
  adc_acu_model adc_acu_model_inst (.clk(clk), .rst_n(rst_n), .crq(crq), .dpr(dpr), .dtr(dtr), .abandon(ab),
    .slow(slow), .ndig(ndig), .pnd_pin(pnd), .acr_pin(acr), .dsr_pin(dsr), .cts_pin(cts), .cos_pin(cos),
    .dlo_pin(dlo), .pwi_pin(pwi));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic dial(input logic [3:0] n);
    dial_go <= 1;
    @(posedge clk);
    dial_go <= 0;
    dig_v <= 1;
    for (int i = 0; i < n; i++) begin
      dig <= 4'(i + 1);
      @(posedge clk);
    end
    dig_v <= 0;
    dial_end <= 1;
    @(posedge clk);
    dial_end <= 0;
    @(posedge clk);
    chk("leds", 8'h03, {6'h0, led_a, led_d});
  endtask
  // Counts cycles with DSR and CTS up until a call event is flagged
  task automatic wait_ev;
    win = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      if (sb[2] === 1'b1 || sb[3] === 1'b1) break;
      if (dsr && cts) win++;
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic hang_up;
    poll <= 1;
    disc <= 1;
    link <= 0;
    @(posedge clk);
    poll <= 0;
    disc <= 0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // Each digit the unit takes must be the next one written, still presented
  always @(posedge clk) begin
    pnd_q <= pnd;
    if (dial_go) begin
      dig_n <= 4'h1;
    end else if (pnd && !pnd_q) begin
      chk("digit", {3'h0, 1'b1, dig_n}, {3'h0, dpr, dig_o});
      dig_n <= dig_n + 4'h1;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("reset", 8'h03, {4'h0, crq, dtr, act, rdl});
    chk("reset_sb", 8'h00, sb);
    chk("reset_t4", 8'h40, t4);
    foreach (rows[r]) begin
      {ndig, ab, sw7, slow} <= {rows[r][15:12], rows[r][10:8]};
      link <= !rows[r][10];
      poll <= 1;
      @(posedge clk);
      poll <= 0;
      dial(rows[r][15:12]);
      wait_ev();
      chk("status", rows[r][7:0], sb);
      chk("srq", {7'h0, rows[r][6]}, {7'h0, srq});
      chk("busy", 8'h00, {7'h0, busy});
      if (!ab) begin
        chk("window", 8'h01, {7'h0, win <= 20});
        repeat (10) @(posedge clk);
        chk("t4", 8'h40, t4);
        chk("t1", 8'h0B, t1);
        chk("t2", 8'h07, t2);
        note <= 1;
        @(posedge clk);
        note <= 0;
        dlv <= 1;
        @(posedge clk);
        dlv <= 0;
        repeat (2) @(posedge clk);
        chk("notify", 8'h80, sb & 8'h80);
      end
      hang_up();
      chk("disc", 8'h00, {6'h0, crq, act});
      repeat (12) @(posedge clk);
      chk("drop", 8'h02, {5'h0, cc, rdl, srq});
    end
    // Unit never finishes: commands refused until interface clear
    {ndig, ab, sw7, slow} <= {4'hF, 3'h0};
    dial(4'h2);
    repeat (20) @(posedge clk);
    hang_up();
    chk("refused", 8'h03, {6'h0, busy, crq});
    ifc <= 1;
    repeat (6) @(posedge clk);
    ifc <= 0;
    chk("ifc", 8'h00, {7'h0, busy});
    hang_up();
    chk("ifc_disc", 8'h00, {7'h0, crq});
    // Far end silent: line dropped after the timeout
    ndig <= 4'h1;
    dial(4'h1);
    wait_ev();
    repeat (28) @(posedge clk);
    chk("dtr_hold", 8'h01, {7'h0, dtr});
    repeat (40) @(posedge clk);
    chk("dtr_drop", 8'h00, {7'h0, dtr});
    hang_up();
    // Front-panel button drops DTR but keeps call request and mode
    dial(4'h1);
    wait_ev();
    btn <= 1;
    repeat (4) @(posedge clk);
    btn <= 0;
    chk("button", 8'h06, {5'h0, crq, act, dtr});
    // Reset in mid-call returns call request, DTR, mode, data-lost and status byte to their reset values
    rst_n <= 0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("rerun", 8'h03, {4'h0, crq, dtr, act, rdl});
    chk("rerun_sb", 8'h00, sb);
    summarize();
  end
endmodule // auto_dial_call_control_tb
`default_nettype wire
